/* File: bench/flash_dev_model.sv */
// Behavioural model of the parallel flash device.
`timescale 1ns/100ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value.
  parameter logic [7:0] DEVICE_CODE = 8'hC3, // Arbitrary value.
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 9000
) (
  // Flash pins.
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic [16:0] address_pins,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out
);
  logic [7:0] mem [0:131071];
  logic [16:0] la;
  logic [7:0] lastd;
  logic [7:0] seen = 8'h00;
  logic busy = 1'b0, tog = 1'b0, idm = 1'b0, lock = 1'b0;
  int st = 0;
  realtime t_low;
  wire stb = !write_n && !chip_sel_n && out_en_n;
  wire drive = !chip_sel_n && !out_en_n && write_n;
  wire [7:0] rd = busy ? {~lastd[7], tog, lastd[5:0]}
    : !idm ? mem[address_pins]
    : address_pins == 17'h2 ? {7'h0, lock}
    : address_pins == 17'h0 ? MAKER_CODE : address_pins == 17'h1 ? DEVICE_CODE : 8'hFF;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // A released bus shows the inverse of its last value, never a lucky match.
  always @(negedge drive) seen = rd;
  assign bus_out = drive ? rd : ~seen;
  always @(negedge out_en_n) if (busy) tog = ~tog;
  always @(posedge stb) begin
    la = address_pins;
    t_low = $realtime;
  end
  // Commands advance on the closing strobe edge; pulses under 15 ns are dropped.
  always @(negedge stb) begin
    if (!busy && $realtime - t_low >= 15) begin
      if (st == 9) begin
        if (!(lock && la <= 17'h1FFF)) begin
          mem[la] = mem[la] & bus_in;
          lastd = bus_in;
          busy = 1'b1;
          busy <= #(PROG_NS) 1'b0;
        end
        st = 0;
      end else if (bus_in == 8'hF0) begin
        idm = 1'b0;
        st = 0;
      end else begin
        case ({st[3:0], la, bus_in})
          {4'd0, 17'h05555, 8'hAA}: st = 1;
          {4'd1, 17'h02AAA, 8'h55}: st = 2;
          {4'd2, 17'h05555, 8'h80}: st = 3;
          {4'd2, 17'h05555, 8'hA0}: st = 9;
          {4'd2, 17'h05555, 8'h90}: begin
            idm = 1'b1;
            st = 0;
          end
          {4'd3, 17'h05555, 8'hAA}: st = 4;
          {4'd4, 17'h02AAA, 8'h55}: st = 5;
          {4'd5, 17'h05555, 8'h40}: begin
            lock = 1'b1;
            st = 0;
          end
          {4'd5, 17'h05555, 8'h10}: begin
            for (int i = 0; i < 131072; i++) begin
              if (!(lock && i < 8192)) mem[i] = 8'hFF;
            end
            lastd = 8'hFF;
            busy = 1'b1;
            busy <= #(ERASE_NS) 1'b0;
            st = 0;
          end
          default: st = 0;
        endcase
      end
    end
  end
endmodule

/* File: bench/flash_host_sva.sv */
// Port checks for the flash host controller.
`timescale 1ns/100ps
module flash_host_sva
  import flash_seq_pkg::*;
#(
  parameter int STROBE_CYC = 5
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Request side.
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic done,
  // Flash pins.
  input wire logic [16:0] address_pins,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic [7:0] data_pins_o,
  input wire logic data_pins_oe_n
);
  int low_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Counts low cycles of the write strobe, so a short pulse is caught.
  always_ff @(posedge sys_clk) low_cnt <= (rst || write_n) ? 0 : low_cnt + 1;
  strobe_no_read_a: assert property (!write_n |-> out_en_n)
    else $error("write strobe while reading");
  no_contention_a: assert property (!out_en_n |-> data_pins_oe_n)
    else $error("host drives data during read");
  addr_hold_a: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(address_pins))
    else $error("address moved while selected");
  data_hold_a: assert property (!write_n |-> !data_pins_oe_n && $stable(data_pins_o))
    else $error("write data not held");
  data_release_a: assert property ($rose(write_n) |-> !data_pins_oe_n)
    else $error("write data released at strobe end");
  strobe_width_a: assert property ($rose(write_n) |-> low_cnt == STROBE_CYC)
    else $error("write strobe width off");
  take_busy_a: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stayed high after take");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  idle_pins_a: assert property (req_ready |-> chip_sel_n && write_n)
    else $error("selects active while idle");
endmodule
bind flash_host flash_host_sva #(.STROBE_CYC(STROBE_CYC)) chk (.sys_clk, .rst, .req_valid,
  .req_ready, .done, .address_pins, .chip_sel_n, .out_en_n, .write_n, .data_pins_o,
  .data_pins_oe_n);

/* File: bench/testbench.sv */
// Self-checking bench: flash host controller against the device model.
`timescale 1ns/100ps
module testbench
  import flash_seq_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEVID = 8'hC3; // Arbitrary value.
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  req_t req = '0;
  logic req_ready, done, locked, chip_sel_n, out_en_n, write_n, data_pins_oe_n;
  logic [7:0] rd_data, data_pins_o;
  logic [16:0] address_pins;
  wire [7:0] dev_q;
  wire [7:0] bus = data_pins_oe_n ? dev_q : data_pins_o;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'd67718;
  logic [7:0] shadow [int];
  logic lock_on = 1'b0;
  flash_host dut (.sys_clk, .rst, .req_valid, .req, .req_ready, .done, .rd_data, .locked,
    .address_pins, .chip_sel_n, .out_en_n, .write_n, .data_pins_o, .data_pins_oe_n,
    .data_pins_i(bus));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) dev (.chip_sel_n, .out_en_n,
    .write_n, .address_pins, .bus_in(bus), .bus_out(dev_q));
  initial forever #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Erased bytes read as all ones until programmed.
  function automatic logic [7:0] cur(int a);
    return shadow.exists(a) ? shadow[a] : 8'hFF;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Both waits are bounded so a stuck handshake ends the run.
  task automatic do_op(input op_t o, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
    req_valid <= 1'b1;
    req <= '{o, a, d};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
    do_op(OP_READ, a, 8'h00);
    check(rd_data, e);
  endtask
  // A locked boot byte keeps its old value.
  task automatic prog(input logic [16:0] a, input logic [7:0] d);
    do_op(OP_PROGRAM, a, d);
    if (!(lock_on && a <= 17'h1FFF)) shadow[a] = cur(a) & d;
    rd_chk(a, cur(a));
  endtask
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(17'h1FFFF, 8'hFF);
    prog(17'h00100, 8'h5A);
    prog(17'h00100, 8'hF3);
    do_op(OP_ID_ENTRY, 17'h0, 8'h00);
    rd_chk(17'h00000, MAKER);
    rd_chk(17'h00001, DEVID);
    do_op(OP_LOCK_QUERY, 17'h2, 8'h00);
    check({7'h0, locked}, 8'h00);
    do_op(OP_ID_EXIT_SHORT, 17'h1234, 8'hF0);
    rd_chk(17'h00001, 8'hFF);
    do_op(OP_LOCKOUT, 17'h0, 8'h00);
    lock_on = 1'b1;
    do_op(OP_ID_ENTRY, 17'h0, 8'h00);
    do_op(OP_LOCK_QUERY, 17'h2, 8'h00);
    check({7'h0, locked}, 8'h01);
    do_op(OP_ID_EXIT, 17'h0, 8'h00);
    rd_chk(17'h00000, 8'hFF);
    prog(17'h01FFF, 8'h00);
    prog(17'h02000, 8'h33);
    do_op(OP_ERASE, 17'h02000, 8'h00);
    rd_chk(17'h00100, 8'h52);
    rd_chk(17'h02000, 8'hFF);
    shadow.delete();
    repeat (6) begin
      r = rnd();
      prog({1'b1, r[15:0]}, r[23:16]);
      prog({1'b1, r[15:0]}, r[31:24]);
    end
    tally_and_finish();
  end
endmodule

/* File: rtl/flash_host.sv */
// Host controller that drives a parallel flash through its pins.
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module flash_host
  import flash_seq_pkg::*;
#(
  parameter int STROBE_CYC = `STROBE_LOW_CYC,
  parameter int GAP_CYCLES = `GAP_CYC,
  parameter int READ_CYCLES = `READ_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Request side.
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic locked,
  // Flash pins.
  output logic [16:0] address_pins,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_n,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe_n,
  input wire logic [7:0] data_pins_i
);

  // ************************************************************
  // State and registers
  // ************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WSETUP = 6'b000010,
    ST_WLOW = 6'b000100,
    ST_WGAP = 6'b001000,
    ST_READ = 6'b010000,
    ST_POLL = 6'b100000
  } state_t;

  state_t state_reg, state_next;
  req_t cur_reg;
  logic [2:0] step_reg;
  logic [7:0] cnt_reg;
  logic [7:0] prev_reg;
  logic have_prev_reg;

  // ************************************************************
  // Sequence decode
  // ************************************************************
  // Number of bus writes each operation needs, a plain read gives none, a lock query falls to 3 but never uses it.
  wire [2:0] seq_len =
    (cur_reg.op == OP_ERASE || cur_reg.op == OP_LOCKOUT) ? 3'h6 :
    (cur_reg.op == OP_PROGRAM) ? 3'h4 :
    (cur_reg.op == OP_ID_EXIT_SHORT) ? 3'h1 :
    (cur_reg.op == OP_READ) ? 3'h0 : 3'h3;
  wire is_read_op = (cur_reg.op == OP_READ) || (cur_reg.op == OP_LOCK_QUERY);
  wire busy_op = (cur_reg.op == OP_PROGRAM) || (cur_reg.op == OP_ERASE);
  // Final command byte of a multi-write sequence.
  wire [7:0] final_cmd =
    (cur_reg.op == OP_ERASE) ? `CMD_ERASE :
    (cur_reg.op == OP_LOCKOUT) ? `CMD_LOCKOUT :
    (cur_reg.op == OP_ID_ENTRY) ? `CMD_ID_ENTRY : `CMD_ID_EXIT;
  // Step of the write about to be set up; in the gap the counter has not advanced yet,
  // so the next pattern is loaded before the strobe and stays put through it.
  wire [2:0] step_sel = (state_reg == ST_WGAP) ? step_reg + 3'h1 : step_reg;
  // Pattern of each write; steps 0, 1, 3 and 4 unlock, steps 2 and 5 write commands, a program's step 3 writes the data, a short exit's step 0 writes its command.
  bus_cycle_t wr_cyc;
  always_comb begin
    wr_cyc = '{addr: `UNLOCK_ADDR1, data: `UNLOCK_DATA1};
    if (cur_reg.op == OP_ID_EXIT_SHORT) begin
      wr_cyc = '{addr: cur_reg.addr, data: `CMD_ID_EXIT};
    end else if (step_sel == 3'h1 || step_sel == 3'h4) begin
      wr_cyc = '{addr: `UNLOCK_ADDR2, data: `UNLOCK_DATA2};
    end else if (step_sel == 3'h2) begin
      wr_cyc = '{addr: `UNLOCK_ADDR1,
        data: (seq_len == 3'h6) ? `CMD_SETUP :
              (seq_len == 3'h4) ? `CMD_PROGRAM : final_cmd};
    end else if (step_sel == 3'h3 && seq_len == 3'h4) begin
      wr_cyc = '{addr: cur_reg.addr, data: cur_reg.data};
    end else if (step_sel == 3'h5) begin
      wr_cyc = '{addr: `UNLOCK_ADDR1, data: final_cmd};
    end
  end
  wire last_step = (step_reg == seq_len - 3'h1);
  wire cnt_hit = (cnt_reg == 8'h00);
  // Completion: bit 6 stops toggling between two successive reads.
  wire settled = have_prev_reg &&
    (prev_reg[`TOGGLE_BIT] == data_pins_i[`TOGGLE_BIT]);
  // One cycle with output-enable released after each poll sample, so each read is distinct.
  wire poll_gap = (state_reg == ST_POLL) && cnt_hit;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          state_next = (req.op == OP_READ || req.op == OP_LOCK_QUERY) ? ST_READ : ST_WSETUP;
        end
      end
      ST_WSETUP: begin
        state_next = ST_WLOW;
      end
      ST_WLOW: begin
        if (cnt_hit) begin
          state_next = ST_WGAP;
        end
      end
      ST_WGAP: begin
        if (cnt_hit) begin
          if (!last_step) begin
            state_next = ST_WSETUP;
          end else if (busy_op) begin
            state_next = ST_POLL;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        if (cnt_hit) begin
          state_next = ST_IDLE;
        end
      end
      ST_POLL: begin
        if (cnt_hit && settled) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Sequencing registers
  // ************************************************************
  // Counter reloads on entry to ST_WLOW, ST_WGAP, ST_READ and ST_POLL so each phase is timed alone.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      step_reg <= 3'h0;
      cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && req_valid) begin
        cur_reg <= req;
        step_reg <= 3'h0;
      end else if (state_reg == ST_WGAP && cnt_hit) begin
        step_reg <= step_reg + 3'h1;
      end
      if (state_next == ST_WLOW && state_reg != ST_WLOW) begin
        cnt_reg <= 8'(STROBE_CYC - 1);
      end else if (state_next == ST_WGAP && state_reg != ST_WGAP) begin
        cnt_reg <= 8'(GAP_CYCLES - 1);
      end else if ((state_next == ST_READ || state_next == ST_POLL) && state_reg != state_next) begin
        cnt_reg <= 8'(READ_CYCLES - 1);
      end else if (state_reg == ST_POLL && cnt_hit) begin
        cnt_reg <= 8'(READ_CYCLES - 1);
      end else if (!cnt_hit) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Output-enable stays high through writes so programs are not inhibited.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      address_pins <= 17'h00000;
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      write_n <= 1'b1;
      data_pins_o <= 8'h00;
      data_pins_oe_n <= 1'b1;
    end else begin
      chip_sel_n <= !(state_next == ST_WLOW || state_next == ST_READ || state_next == ST_POLL);
      write_n <= !(state_next == ST_WLOW);
      out_en_n <= !(state_next == ST_READ || (state_next == ST_POLL && !poll_gap));
      // Data is driven across setup, strobe and gap so it is stable at the rising edge.
      data_pins_oe_n <= !(state_next == ST_WSETUP || state_next == ST_WLOW ||
        state_next == ST_WGAP);
      if (state_reg == ST_WSETUP || (state_reg == ST_WGAP && state_next == ST_WSETUP)) begin
        address_pins <= wr_cyc.addr;
        data_pins_o <= wr_cyc.data;
      end else if (state_reg == ST_IDLE && state_next == ST_WSETUP) begin
        address_pins <= (req.op == OP_ID_EXIT_SHORT) ? req.addr : `UNLOCK_ADDR1;
        data_pins_o <= (req.op == OP_ID_EXIT_SHORT) ? `CMD_ID_EXIT : `UNLOCK_DATA1;
      end else if (state_reg == ST_IDLE && state_next == ST_READ) begin
        address_pins <= (req.op == OP_LOCK_QUERY) ? `LOCK_STATUS_ADDR : req.addr;
      end else if (state_next == ST_POLL && state_reg != ST_POLL) begin
        address_pins <= cur_reg.addr;
      end
    end
  end

  // ************************************************************
  // Answers
  // ************************************************************
  // Each poll read is ended with an output-enable release so the device sees separate reads.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
      locked <= 1'b0;
      prev_reg <= 8'h00;
      have_prev_reg <= 1'b0;
    end else begin
      req_ready <= (state_next == ST_IDLE);
      done <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
      if (state_reg == ST_POLL && state_next != ST_POLL) begin
        have_prev_reg <= 1'b0;
      end else if (state_reg == ST_POLL && cnt_hit) begin
        prev_reg <= data_pins_i;
        have_prev_reg <= 1'b1;
      end
      if ((state_reg == ST_READ || state_reg == ST_POLL) && cnt_hit) begin
        rd_data <= data_pins_i;
      end
      if (state_reg == ST_READ && cnt_hit && is_read_op && cur_reg.op == OP_LOCK_QUERY) begin
        locked <= data_pins_i[`LOCK_STATUS_BIT];
      end
    end
  end

endmodule

/* File: rtl/flash_seq_map.svh */
// Constants for the parallel flash command sequencer host.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define UNLOCK_ADDR1 17'h05555
`define UNLOCK_ADDR2 17'h02AAA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55
`define CMD_SETUP 8'h80
`define CMD_ERASE 8'h10
`define CMD_PROGRAM 8'hA0
`define CMD_LOCKOUT 8'h40
`define CMD_ID_ENTRY 8'h90
`define CMD_ID_EXIT 8'hF0
`define LOCK_STATUS_ADDR 17'h00002
`define BOOT_BLOCK_LAST 17'h01FFF
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define LOCK_STATUS_BIT 0
`define CLK_PERIOD_NS 20
`define STROBE_LOW_NS 100
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_NS 40
`define GAP_CYC ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_NS 120
`define READ_CYC ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: rtl/flash_seq_pkg.sv */
// Types for the parallel flash command sequencer host.
package flash_seq_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE = 3'h2,
    OP_LOCKOUT = 3'h3,
    OP_ID_ENTRY = 3'h4,
    OP_ID_EXIT = 3'h5,
    OP_ID_EXIT_SHORT = 3'h6,
    OP_LOCK_QUERY = 3'h7
  } op_t;
  typedef struct packed {
    op_t op;
    logic [16:0] addr;
    logic [7:0] data;
  } req_t;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } bus_cycle_t;
endpackage
